// ===== include/gpt_regs.vh
`ifndef GPT_REGS_VH
`define GPT_REGS_VH
// Control word field positions
`define GPT_CTL_ON 15
`define GPT_CTL_STOP_IN_IDLE 13
`define GPT_CTL_GATE 7
`define GPT_CTL_PS_HI 6
`define GPT_CTL_PS_LO 4
`define GPT_CTL_PAIR 3
`define GPT_CTL_SRC 1
`define GPT_CTL_WIDTH 16
`define GPT_CTL_RESET 16'h0000
`define GPT_CNT_RESET 16'h0000
`define GPT_PER_RESET 16'hffff
`define GPT_SYNC_STAGES 2
// Source clocks per count for each prescale code
`define GPT_PS_DIV0 9'h001
`define GPT_PS_DIV1 9'h002
`define GPT_PS_DIV2 9'h004
`define GPT_PS_DIV3 9'h008
`define GPT_PS_DIV4 9'h010
`define GPT_PS_DIV5 9'h020
`define GPT_PS_DIV6 9'h040
`define GPT_PS_DIV7 9'h100
`endif

// ===== design/gpt_pair.v
`timescale 1ns/10ps
`include "gpt_regs.vh"
// Function
// RQ1: Gated mode counts only peripheral clock; external source disables gating.
// RQ2: Gate rising edge enables counting; every clock counts at prescale 1:1.
// RQ3: Gated match clears counter next clock, no match event, keeps counting.
// RQ4: Gate falling edge raises gate event, stops counting, counter holds.
// RQ5: Internal source with prescale N advances counter every Nth clock.
// RQ6: Software configures gated mode while disabled, enabling last.
// RQ7: Software clears timer-on before reconfiguring, sets it last.
// RQ8: Pair bit with internal source forms one 32-bit counter at 1:1.
// RQ9: 32-bit internal match raises event and clears counter next clock.
// RQ10: Chaining only between timers two-three and four-five; even is low half.
// RQ11: Enabled even timer with pair bit enables odd partner automatically.
// RQ12: In 32-bit operation even control used; odd control writes ignored.
// RQ13: In 32-bit gated or external modes even pin used, odd pin ignored.
// RQ14: In 32-bit operation events go to odd flag; even flag ignored.
// RQ15: Even count and period writes load whole 32-bit pair.
// RQ16: 32-bit external mode counts each synchronised rising external edge at 1:1.
// RQ17: 32-bit external match raises event, clears counter next external edge.
// RQ18: External source with prescale N advances every Nth external edge.
// RQ19: Prescale codes map to 1,2,4,8,16,32,64,256 source clocks per count.
// RQ20: Clearing timer-on stops timer; other control bits stay unchanged.
// RQ21: Stop-in-idle halts the timer during processor idle.
// RQ22: Match or gate event sets sticky flag until software clears it.
// RQ23: Gate/clock pin passes two-stage synchroniser before edge detection.
module gpt_pair #(
  parameter CW = 16
) (
  // Clock and reset
  input wire CLK,
  input wire SRST,
  // Processor state
  input wire CPU_IDLE,
  // Control words
  input wire EVEN_CTL_WE,
  input wire [CW-1:0] EVEN_CTL_WD,
  input wire ODD_CTL_WE,
  input wire [CW-1:0] ODD_CTL_WD,
  output wire [CW-1:0] EVEN_CTL,
  output wire [CW-1:0] ODD_CTL,
  // Count and period loads, 32-bit writes through the even registers
  input wire EVEN_CNT_WE,
  input wire ODD_CNT_WE,
  input wire [2*CW-1:0] CNT_WD,
  input wire EVEN_PER_WE,
  input wire ODD_PER_WE,
  input wire [2*CW-1:0] PER_WD,
  output wire [CW-1:0] EVEN_CNT,
  output wire [CW-1:0] ODD_CNT,
  output wire [CW-1:0] EVEN_PER,
  output wire [CW-1:0] ODD_PER,
  // Clock or gate pins
  input wire EVEN_PIN,
  input wire ODD_PIN,
  // Event flags and enables
  input wire EVEN_FLAG_CLR,
  input wire ODD_FLAG_CLR,
  input wire EVEN_EVT_EN,
  input wire ODD_EVT_EN,
  output wire EVEN_FLAG,
  output wire ODD_FLAG,
  output wire EVEN_IRQ,
  output wire ODD_IRQ
);

  reg [CW-1:0] ctl [0:1];
  reg [CW-1:0] cnt [0:1];
  reg [CW-1:0] per [0:1];
  reg [1:0] sync1, sync2, sync3;
  reg [1:0] flag;
  reg [1:0] next_flag;
  reg [1:0] evt;
  reg [1:0] pin_rise;
  reg [1:0] pin_fall;
  reg [CW-1:0] next_ctl0;
  reg [CW-1:0] next_ctl1;
  reg [CW-1:0] next_cnt0;
  reg [CW-1:0] next_cnt1;
  reg [CW-1:0] next_per0;
  reg [CW-1:0] next_per1;
  wire [1:0] gate_run;
  wire pair = ctl[0][`GPT_CTL_PAIR];
  wire [1:0] rise = sync2 & ~sync3;
  wire [1:0] fall = ~sync2 & sync3;

  // Count length per prescale code
  function [8:0] ps_len;
    input [2:0] code;
    begin
      case (code) // RQ19
        3'h0: ps_len = `GPT_PS_DIV0;
        3'h1: ps_len = `GPT_PS_DIV1;
        3'h2: ps_len = `GPT_PS_DIV2;
        3'h3: ps_len = `GPT_PS_DIV3;
        3'h4: ps_len = `GPT_PS_DIV4;
        3'h5: ps_len = `GPT_PS_DIV5;
        3'h6: ps_len = `GPT_PS_DIV6;
        default: ps_len = `GPT_PS_DIV7;
      endcase
    end
  endfunction

  // Increment, or wrap to zero on a period match
  function [2*CW-1:0] step;
    input [2*CW-1:0] value;
    input [2*CW-1:0] limit;
    begin
      if (value == limit)
        step = {(2*CW){1'b0}};
      else
        step = value + {{(2*CW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Pin synchroniser; first stage feeds only the second
  always @(posedge CLK) begin // RQ23
    if (SRST) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      sync3 <= 2'h0;
    end else begin
      sync1 <= {ODD_PIN, EVEN_PIN};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Control words
  always @(posedge CLK) begin
    if (SRST) begin
      ctl[0] <= `GPT_CTL_RESET;
      ctl[1] <= `GPT_CTL_RESET;
    end else begin
      ctl[0] <= next_ctl0;
      ctl[1] <= next_ctl1;
    end
  end

  // Odd word frozen while paired, so a stray write cannot split the pair
  always @* begin
    next_ctl0 = ctl[0];
    next_ctl1 = ctl[1];
    if (EVEN_CTL_WE)
      next_ctl0 = EVEN_CTL_WD;
    if (ODD_CTL_WE && !pair)
      next_ctl1 = ODD_CTL_WD; // RQ12
  end

  // Per-timer control decode; odd follows even while paired
  wire [CW-1:0] eff1 = pair ? ctl[0] : ctl[1]; // RQ11 RQ12
  wire [1:0] on = {eff1[`GPT_CTL_ON], ctl[0][`GPT_CTL_ON]};
  wire [1:0] stop_in_idle = {eff1[`GPT_CTL_STOP_IN_IDLE], ctl[0][`GPT_CTL_STOP_IN_IDLE]};
  wire [1:0] ext = {eff1[`GPT_CTL_SRC], ctl[0][`GPT_CTL_SRC]};
  // Gating only meaningful with internal source
  wire [1:0] gated = {eff1[`GPT_CTL_GATE], ctl[0][`GPT_CTL_GATE]} & ~ext; // RQ1
  // In pair mode both halves use the even pin
  always @* begin
    pin_rise = rise;
    pin_fall = fall;
    if (pair) begin
      pin_rise = {2{rise[0]}}; // RQ13
      pin_fall = {2{fall[0]}}; // RQ13
    end
  end
  wire [1:0] halt = ~on | (stop_in_idle & {2{CPU_IDLE}}); // RQ20 RQ21

  // Source tick: peripheral clock, or synced external edge
  wire [1:0] src_tick = (ext & pin_rise) | (~ext & (~gated | gate_run)); // RQ2 RQ16
  wire [1:0] ps_done;
  wire [1:0] tick;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gp
      wire [2:0] code = (g == 1 && pair) ? ctl[0][`GPT_CTL_PS_HI:`GPT_CTL_PS_LO] :
                        ctl[g][`GPT_CTL_PS_HI:`GPT_CTL_PS_LO];
      wire [8:0] len = ps_len(code);
      // Own count write; the odd one is ignored while paired
      wire load = pair ? EVEN_CNT_WE : (g == 0 ? EVEN_CNT_WE : ODD_CNT_WE);
      reg [8:0] pre;
      reg run;
      assign ps_done[g] = (pre == len - 9'h001);
      assign tick[g] = src_tick[g] & ps_done[g] & ~halt[g]; // RQ5 RQ18
      assign gate_run[g] = run;
      // Prescale counter cleared on disable and on count writes
      always @(posedge CLK) begin
        if (SRST || !on[g] || load)
          pre <= 9'h000;
        else if (src_tick[g] && !halt[g])
          pre <= ps_done[g] ? 9'h000 : pre + 9'h001;
      end
      // Gate window
      always @(posedge CLK) begin
        if (SRST || !on[g] || !gated[g])
          run <= 1'b0;
        else if (pin_rise[g])
          run <= 1'b1; // RQ2
        else if (pin_fall[g])
          run <= 1'b0; // RQ4
      end
    end
  endgenerate

  // Match: 16-bit per timer or 32-bit on the pair
  wire [2*CW-1:0] cnt32 = {cnt[1], cnt[0]};
  wire [2*CW-1:0] per32 = {per[1], per[0]};
  wire match32 = (cnt32 == per32);
  wire [1:0] match16 = {cnt[1] == per[1], cnt[0] == per[0]};
  wire [2*CW-1:0] step_pair = step(cnt32, per32);
  wire [2*CW-1:0] step_even = step({{CW{1'b0}}, cnt[0]}, {{CW{1'b0}}, per[0]});
  wire [2*CW-1:0] step_odd = step({{CW{1'b0}}, cnt[1]}, {{CW{1'b0}}, per[1]});

  // Events; gated match stays silent
  wire [1:0] gate_evt = gated & gate_run & pin_fall & ~halt; // RQ4
  wire [1:0] match_evt = {~pair & tick[1] & match16[1] & ~gated[1],
                          ~pair & tick[0] & match16[0] & ~gated[0]}; // RQ3
  wire pair_evt = pair & ((tick[0] & match32 & ~gated[0]) | gate_evt[0]); // RQ9 RQ17
  // Even flag idles while paired so software sees one source
  always @* begin
    evt = match_evt | gate_evt;
    if (pair)
      evt = {pair_evt, 1'b0}; // RQ14
  end

  // Count and period registers
  always @(posedge CLK) begin
    if (SRST) begin
      cnt[0] <= `GPT_CNT_RESET;
      cnt[1] <= `GPT_CNT_RESET;
      per[0] <= `GPT_PER_RESET;
      per[1] <= `GPT_PER_RESET;
    end else begin
      cnt[0] <= next_cnt0;
      cnt[1] <= next_cnt1;
      per[0] <= next_per0;
      per[1] <= next_per1;
    end
  end

  // Next count and period; a count write wins over a tick in the same cycle
  always @* begin
    next_cnt0 = cnt[0];
    next_cnt1 = cnt[1];
    next_per0 = per[0];
    next_per1 = per[1];
    if (pair) begin
      if (EVEN_PER_WE) begin
        next_per0 = PER_WD[CW-1:0]; // RQ15
        next_per1 = PER_WD[2*CW-1:CW]; // RQ15
      end
      if (EVEN_CNT_WE) begin
        next_cnt0 = CNT_WD[CW-1:0]; // RQ15
        next_cnt1 = CNT_WD[2*CW-1:CW]; // RQ15
      end else if (tick[0]) begin
        // Even half is the low word of the chained count
        next_cnt0 = step_pair[CW-1:0]; // RQ8 RQ9 RQ10
        next_cnt1 = step_pair[2*CW-1:CW]; // RQ8 RQ9 RQ10
      end
    end else begin
      if (EVEN_PER_WE)
        next_per0 = PER_WD[CW-1:0];
      if (ODD_PER_WE)
        next_per1 = PER_WD[CW-1:0];
      if (EVEN_CNT_WE)
        next_cnt0 = CNT_WD[CW-1:0];
      else if (tick[0])
        next_cnt0 = step_even[CW-1:0]; // RQ3
      if (ODD_CNT_WE)
        next_cnt1 = CNT_WD[CW-1:0];
      else if (tick[1])
        next_cnt1 = step_odd[CW-1:0]; // RQ3
    end
  end

  // Sticky flags; set wins over clear
  always @(posedge CLK) begin
    if (SRST)
      flag <= 2'h0;
    else
      flag <= next_flag;
  end

  always @* begin
    next_flag = flag & ~{ODD_FLAG_CLR, EVEN_FLAG_CLR};
    next_flag = next_flag | evt; // RQ22
  end

  assign EVEN_CTL = ctl[0];
  assign ODD_CTL = ctl[1];
  assign EVEN_CNT = cnt[0];
  assign ODD_CNT = cnt[1];
  assign EVEN_PER = per[0];
  assign ODD_PER = per[1];
  assign EVEN_FLAG = flag[0];
  assign ODD_FLAG = flag[1];
  // Even enable ignored while paired
  assign EVEN_IRQ = flag[0] & EVEN_EVT_EN & ~pair; // RQ14
  assign ODD_IRQ = flag[1] & ODD_EVT_EN;

endmodule // gpt_pair

// ===== verif/gpt_pair_props.sv
`timescale 1ns/10ps
module gpt_pair_props #(
  parameter CW = 16
) (
  // Clock, reset and idle
  input wire logic CLK, SRST, CPU_IDLE,
  // Writes
  input wire logic ODD_CTL_WE, EVEN_CNT_WE, ODD_CNT_WE, EVEN_PER_WE,
  input wire logic [2*CW-1:0] CNT_WD, PER_WD,
  // Stored state
  input wire logic [CW-1:0] EVEN_CTL, ODD_CTL, EVEN_CNT, ODD_CNT, EVEN_PER, ODD_PER,
  // Events
  input wire logic ODD_FLAG_CLR, ODD_EVT_EN, ODD_FLAG, EVEN_IRQ, ODD_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  wire pair = EVEN_CTL[3];
  wire nowr = !EVEN_CNT_WE && !ODD_CNT_WE;
  wire [2*CW-1:0] cnt = {ODD_CNT, EVEN_CNT};
  // Plain 1:1 internal pair, not halted and not overwritten
  wire run32 = EVEN_CTL[15] && pair && EVEN_CTL[7:4] == 4'h0 && !EVEN_CTL[1] && !CPU_IDLE && nowr;
  cnt_step_a: assert property (run32 && cnt != {ODD_PER, EVEN_PER} |=>
    cnt == {$past(ODD_CNT), $past(EVEN_CNT)} + 1'b1) else $error("pair count did not step");
  match_wrap_a: assert property (run32 && cnt == {ODD_PER, EVEN_PER} |=>
    cnt == 0 && ODD_FLAG) else $error("pair match did not wrap");
  flag_hold_a: assert property (ODD_FLAG && !ODD_FLAG_CLR |=> ODD_FLAG)
    else $error("flag dropped");
  irq_route_a: assert property (ODD_IRQ == (ODD_FLAG && ODD_EVT_EN) && !(pair && EVEN_IRQ))
    else $error("irq routing");
  odd_lock_a: assert property (pair && ODD_CTL_WE |=> $stable(ODD_CTL))
    else $error("odd control changed");
  off_hold_a: assert property (!EVEN_CTL[15] && nowr |=> $stable(EVEN_CNT))
    else $error("count moved while off");
  idle_hold_a: assert property (EVEN_CTL[13] && CPU_IDLE && nowr |=> $stable(EVEN_CNT))
    else $error("count moved in idle");
  cnt_load_a: assert property (pair && EVEN_CNT_WE |=> cnt == $past(CNT_WD))
    else $error("count pair load");
  per_load_a: assert property (pair && EVEN_PER_WE |=> {ODD_PER, EVEN_PER} == $past(PER_WD))
    else $error("period pair load");
endmodule // gpt_pair_props
bind gpt_pair gpt_pair_props #(.CW(CW)) chk_u (
  .CLK(CLK), .SRST(SRST), .CPU_IDLE(CPU_IDLE), .ODD_CTL_WE(ODD_CTL_WE),
  .EVEN_CNT_WE(EVEN_CNT_WE), .ODD_CNT_WE(ODD_CNT_WE), .EVEN_PER_WE(EVEN_PER_WE),
  .CNT_WD(CNT_WD), .PER_WD(PER_WD), .EVEN_CTL(EVEN_CTL), .ODD_CTL(ODD_CTL),
  .EVEN_CNT(EVEN_CNT), .ODD_CNT(ODD_CNT), .EVEN_PER(EVEN_PER), .ODD_PER(ODD_PER),
  .ODD_FLAG_CLR(ODD_FLAG_CLR), .ODD_EVT_EN(ODD_EVT_EN), .ODD_FLAG(ODD_FLAG),
  .EVEN_IRQ(EVEN_IRQ), .ODD_IRQ(ODD_IRQ)
);

// ===== verif/gpt_pin_src.sv
`timescale 1ns/10ps
module gpt_pin_src (
  // Bench controls
  input wire logic ext_run,
  input wire logic gate,
  // Clock or gate pin
  output logic pin
);
  // Clock only inside a burst; between bursts the pin rests at the gate level
  always begin
    if (ext_run) begin
      pin = 1'b1;
      #30;
      pin = 1'b0;
      #30;
    end else begin
      pin = gate;
      #1;
    end
  end
endmodule // gpt_pin_src

// ===== verif/gpt_pair_test.sv
`timescale 1ns/10ps
module gpt_pair_test;
  logic CLK = 0, SRST = 1, CPU_IDLE = 0, EVEN_CTL_WE = 0, ODD_CTL_WE = 0, ext_run = 0, gate = 0;
  logic EVEN_CNT_WE = 0, ODD_CNT_WE = 0, EVEN_PER_WE = 0, ODD_PER_WE = 0, ODD_PIN = 0;
  logic EVEN_FLAG_CLR = 0, ODD_FLAG_CLR = 0, EVEN_EVT_EN = 1, ODD_EVT_EN = 1;
  logic [15:0] EVEN_CTL_WD = 0, ODD_CTL_WD = 0, EVEN_CTL, ODD_CTL, EVEN_CNT, ODD_CNT, EVEN_PER, ODD_PER, held;
  logic [31:0] CNT_WD = 0, PER_WD = 0;
  wire EVEN_PIN, EVEN_FLAG, ODD_FLAG, EVEN_IRQ, ODD_IRQ;
  int n_errors = 0, comparisons = 0, i;
  // Prescale code beside its divide ratio
  logic [11:0] rows [8] = '{12'h001, 12'h202, 12'h404, 12'h608, 12'h810, 12'ha20, 12'hc40, 12'hf00};
  gpt_pair #(.CW(16)) dut_u (
    .CLK(CLK), .SRST(SRST), .CPU_IDLE(CPU_IDLE),
    .EVEN_CTL_WE(EVEN_CTL_WE), .EVEN_CTL_WD(EVEN_CTL_WD),
    .ODD_CTL_WE(ODD_CTL_WE), .ODD_CTL_WD(ODD_CTL_WD),
    .EVEN_CTL(EVEN_CTL), .ODD_CTL(ODD_CTL),
    .EVEN_CNT_WE(EVEN_CNT_WE), .ODD_CNT_WE(ODD_CNT_WE), .CNT_WD(CNT_WD),
    .EVEN_PER_WE(EVEN_PER_WE), .ODD_PER_WE(ODD_PER_WE), .PER_WD(PER_WD),
    .EVEN_CNT(EVEN_CNT), .ODD_CNT(ODD_CNT), .EVEN_PER(EVEN_PER), .ODD_PER(ODD_PER),
    .EVEN_PIN(EVEN_PIN), .ODD_PIN(ODD_PIN),
    .EVEN_FLAG_CLR(EVEN_FLAG_CLR), .ODD_FLAG_CLR(ODD_FLAG_CLR),
    .EVEN_EVT_EN(EVEN_EVT_EN), .ODD_EVT_EN(ODD_EVT_EN),
    .EVEN_FLAG(EVEN_FLAG), .ODD_FLAG(ODD_FLAG), .EVEN_IRQ(EVEN_IRQ), .ODD_IRQ(ODD_IRQ)
  );
  gpt_pin_src src_u (.ext_run(ext_run), .gate(gate), .pin(EVEN_PIN));
  initial forever #4 CLK = ~CLK;
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ctl(logic [15:0] v);
    @(negedge CLK) EVEN_CTL_WD = v;
    EVEN_CTL_WE = 1;
    @(negedge CLK) EVEN_CTL_WE = 0;
  endtask
  task automatic ld(logic [31:0] c, logic [31:0] p);
    @(negedge CLK) {CNT_WD, PER_WD, EVEN_CNT_WE, EVEN_PER_WE} = {c, p, 2'b11};
    @(negedge CLK) {EVEN_CNT_WE, EVEN_PER_WE} = 2'b00;
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge CLK);
    SRST = 0;
    @(negedge CLK);
    chk("reset period", 16'hffff, EVEN_PER);
    chk("reset count", 16'h0, ODD_CNT);
    for (i = 0; i < 8; i++) begin
      ctl({1'b0, 8'h00, rows[i][11:9], 4'h8});
      ld(0, 32'hffffffff);
      ctl({1'b1, 8'h00, rows[i][11:9], 4'h8});
      repeat (3 * rows[i][8:0] - 2) @(negedge CLK);
      ctl({1'b0, 8'h00, rows[i][11:9], 4'h8});
      chk("scaled count", 3, EVEN_CNT);
      chk("ctl kept", {1'b0, 8'h00, rows[i][11:9], 4'h8}, EVEN_CTL);
    end
    ld(0, 4);
    chk("pair period", 4, {ODD_PER, EVEN_PER});
    ctl(16'h0008);
    ctl(16'h8008);
    for (i = 0; i < 20 && ODD_FLAG !== 1'b1; i++) @(negedge CLK);
    if (i == 20) begin
      n_errors++;
      wrap_up();
    end
    chk("wrap", 0, {ODD_CNT, EVEN_CNT});
    chk("odd irq", 1, ODD_IRQ);
    chk("even irq", 0, EVEN_IRQ);
    {ODD_CTL_WD, ODD_CTL_WE} = {16'h8072, 1'b1};
    @(negedge CLK) ODD_CTL_WE = 0;
    chk("odd ctl", 0, ODD_CTL);
    ctl(16'h2008);
    CPU_IDLE = 1;
    ld(0, 4);
    ctl(16'ha008);
    repeat (4) @(negedge CLK);
    chk("idle count", 0, EVEN_CNT);
    {ODD_FLAG_CLR, CPU_IDLE} = 2'b10;
    @(negedge CLK) ODD_FLAG_CLR = 0;
    chk("flag clear", 0, ODD_FLAG);
    ctl(16'h2008);
    ctl(16'h0000);
    ld(0, 3);
    ctl(16'h0080);
    ctl(16'h8080);
    gate = 1;
    repeat (12) @(negedge CLK);
    chk("gated no event", 0, EVEN_FLAG);
    chk("gated wrap", 1, EVEN_CNT < 4);
    gate = 0;
    repeat (6) @(negedge CLK);
    held = EVEN_CNT;
    chk("gate event", 1, EVEN_IRQ);
    repeat (3) @(negedge CLK);
    chk("gate hold", held, EVEN_CNT);
    ctl(16'h0080);
    ctl(16'h000a);
    ld(0, 2);
    ctl(16'h800a);
    ext_run = 1;
    ODD_PIN = 1;
    #400 ext_run = 0;
    repeat (8) @(negedge CLK);
    chk("ext count", 1, {ODD_CNT, EVEN_CNT});
    chk("ext match", 1, ODD_FLAG);
    chk("odd pin ignored", 1, {ODD_CNT, EVEN_CNT});
    @(negedge CLK) SRST = 1;
    @(negedge CLK) SRST = 0;
    @(negedge CLK);
    chk("second reset ctl", 0, EVEN_CTL);
    chk("second reset flag", 0, ODD_FLAG);
    chk("second reset period", 32'hffffffff, {ODD_PER, EVEN_PER});
    wrap_up();
  end
endmodule // gpt_pair_test
